// *** shared/cc_pkg.sv ***
/*
 * Constants, register map, field layout and carrier types for the
 * three-channel capture/compare counter array.
 * Assumes a byte-wide register port on the system clock; all addresses
 * below are byte addresses on that port.
 */
package cc_pkg;

    localparam int CNT_W  = 16;                // counter and register width
    localparam int DATA_W = 8;                 // register port data width
    localparam int ADDR_W = 8;                 // register port address width

    // register addresses
    localparam logic [ADDR_W-1:0] ADDR_ARRAY_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_ARRAY_MODE = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_CNT_LO     = 8'h02;
    localparam logic [ADDR_W-1:0] ADDR_CNT_HI     = 8'h03;
    localparam logic [ADDR_W-1:0] ADDR_PWM_CTRL   = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_PIN_STATE  = 8'h05;
    localparam logic [ADDR_W-1:0] ADDR_MODE_BASE  = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_CMP_BASE   = 8'h10;

    // array_control field positions
    localparam int ACTL_WRAP_BIT = 7;          // counter_wrap_flag
    localparam int ACTL_RUN_BIT  = 6;          // counter run enable
    // channel_event_flag n sits at bit n

    // array_mode field positions
    localparam int AMOD_IEN_BIT = 0;           // counter_wrap_irq_en

    // shared_pwm_control field positions
    localparam int PWMC_ARSEL_BIT = 7;         // auto-reload access select
    localparam int PWMC_IEN_BIT   = 6;         // intermediate_wrap_irq_en
    localparam int PWMC_FLAG_BIT  = 5;         // intermediate_wrap_flag

    // values after reset
    localparam logic [DATA_W-1:0] MODE_RST = 8'h00;
    localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;
    localparam logic [CNT_W-1:0]  CMP_RST  = 16'h0000;
    localparam logic [1:0]        CYCLE_LENGTH_SEL_RST = 2'h0;

    // channel_mode_control layout, bit 7 first
    typedef struct packed {
        logic pwm16;            // 16-bit PWM select
        logic comparator_en;    // digital comparator on
        logic rise_capture_sel; // capture on rising edge
        logic fall_capture_sel; // capture on falling edge
        logic match_flag_en;    // match sets channel flag
        logic toggle_en;        // toggle output on match
        logic pulse_mode_en;    // PWM / frequency output
        logic channel_irq_en;   // channel flag raises request
    } mode_type;

    // one register port request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } sfr_req_type;

    // low-bit mask of the shared 8..11-bit PWM cycle
    function automatic logic [CNT_W-1:0] cycle_mask(input logic [1:0] sel);
        unique case (sel)
            2'h0: cycle_mask = 16'h00FF;
            2'h1: cycle_mask = 16'h01FF;
            2'h2: cycle_mask = 16'h03FF;
            2'h3: cycle_mask = 16'h07FF;
        endcase
    endfunction

    // address of a per-channel register from its base
    function automatic logic [ADDR_W-1:0] chan_addr(
        input logic [ADDR_W-1:0] base,
        input int                idx,
        input int                stride);
        chan_addr = base + ADDR_W'(idx * stride);
    endfunction

endpackage

// *** hdl/pin_edge_detect.sv ***
/*
 * Two-flop synchroniser and edge detector for the channel pins.
 * Assumes pins are asynchronous to REF clock; first flop feeds only
 * the second one.
 */
`timescale 1ns/100ps
module pin_edge_detect #(
    parameter int W = 3
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o,
    output logic      [W-1:0] rise_o,
    output logic      [W-1:0] fall_o
);
    logic [W-1:0] meta_q;   // first stage, read by sync_q only
    logic [W-1:0] sync_q;   // settled level
    logic [W-1:0] prev_q;   // level one clock earlier

    // levels shorter than one clock may slip through unseen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_o = sync_q;
    assign rise_o  = sync_q & ~prev_q;
    assign fall_o  = ~sync_q & prev_q;
endmodule

// *** hdl/array_counter.sv ***
/*
 * The 16-bit counter shared by all channels, with its full and
 * intermediate wrap strobes.
 * Assumes step_i is a one-clock timebase tick from REF clock logic.
 */
`timescale 1ns/100ps
module array_counter
    import cc_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              step_i,    // counter advances now
    input  wire logic              wr_lo_i,   // software writes low byte
    input  wire logic              wr_hi_i,   // software writes high byte
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic [1:0]        cycle_length_sel_i,   // shared cycle length
    output logic      [CNT_W-1:0]  cnt_o,
    output logic                   wrap_o,    // 0xFFFF to 0x0000 now
    output logic                   mid_wrap_o // carry out of bit N now
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] mask;

    // software writes win over the advance
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= CNT_RST;
        end else if (wr_lo_i) begin
            cnt_q[7:0] <= wdata_i;
        end else if (wr_hi_i) begin
            cnt_q[15:8] <= wdata_i;
        end else if (step_i) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    assign mask       = cycle_mask(cycle_length_sel_i);
    assign cnt_o      = cnt_q;
    assign wrap_o     = step_i & (&cnt_q);
    assign mid_wrap_o = step_i & ((cnt_q & mask) == mask);
endmodule

// *** hdl/counter_array_capture_compare.sv ***
/*
 * Capture/compare counter array: shared counter, three channels with
 * capture, software timer, toggle, frequency and PWM modes, event
 * flags and one interrupt request.
 * Assumes a byte register port on REF_CLK_I, a one-clock TICK_I from
 * the timebase selector, and pins that are asynchronous.
 */
`timescale 1ns/100ps
module counter_array_capture_compare
    import cc_pkg::*;
#(
    parameter int NUM_CH = 3
) (
    input  wire logic              REF_CLK_I,
    input  wire logic              SYS_RST_I,
    input  wire logic              TICK_I,
    input  wire logic              SFR_WR_I,
    input  wire logic              SFR_RD_I,
    input  wire logic [ADDR_W-1:0] SFR_ADDR_I,
    input  wire logic [DATA_W-1:0] SFR_WDATA_I,
    input  wire logic [NUM_CH-1:0] CH_PIN_I,
    output logic      [DATA_W-1:0] SFR_RDATA_O,
    output logic      [NUM_CH-1:0] CH_PIN_O,
    output logic      [NUM_CH-1:0] CH_PIN_OE_O,
    output logic                   IRQ_O
);
    // flags share array_control with run and wrap bits
    if (NUM_CH < 1 || NUM_CH > 3) begin : g_bad_num_ch
        $error("NUM_CH must be 1 to 3");
    end

    sfr_req_type      req;            // bundled register request
    logic [CNT_W-1:0] cnt;            // shared counter value
    logic             cnt_wrap;       // full wrap this clock
    logic             mid_wrap;       // intermediate wrap this clock
    logic             step;           // counter advances this clock
    logic             run_q;          // counter run enable
    logic             wrap_flag_q;    // counter_wrap_flag
    logic             mid_flag_q;     // intermediate_wrap_flag
    logic             wrap_ien_q;     // counter_wrap_irq_en
    logic             mid_ien_q;      // intermediate_wrap_irq_en
    logic             arsel_q;        // reload register access select
    logic [1:0]       cycle_length_sel_q;        // cycle_length_sel
    logic [NUM_CH-1:0] ch_flag_q;     // channel_event_flag
    logic [NUM_CH-1:0] ch_set;        // channel flag set events
    logic [NUM_CH-1:0] ch_ien;        // channel_irq_en bits
    logic [NUM_CH-1:0] pin_lvl;       // synchronised pin levels
    logic [NUM_CH-1:0] pin_rise;
    logic [NUM_CH-1:0] pin_fall;
    logic [CNT_W-1:0]  mask;          // shared PWM cycle mask
    logic [DATA_W-1:0] rd_data;       // read mux result
    logic [DATA_W-1:0] ctrl_rd;       // array_control read image
    logic              wr_ctrl;
    logic              wr_amod;
    logic              wr_pwmc;
    logic              irq_d;

    mode_type          mode_q [NUM_CH];  // channel_mode_control
    logic [CNT_W-1:0]  cmp_q  [NUM_CH];  // compare/capture register
    logic [CNT_W-1:0]  rld_q  [NUM_CH];  // auto-reload register
    logic [NUM_CH-1:0] pend_q;           // edge waiting for a tick
    logic [NUM_CH-1:0] pin_q;            // driven pin levels
    logic [NUM_CH-1:0] oe_q;             // pin output enables

    assign req.wr    = SFR_WR_I;
    assign req.rd    = SFR_RD_I;
    assign req.addr  = SFR_ADDR_I;
    assign req.wdata = SFR_WDATA_I;

    // every match and capture evaluation below waits for the counter to step
    assign step    = run_q & TICK_I;
    assign mask    = cycle_mask(cycle_length_sel_q);
    assign wr_ctrl = req.wr & (req.addr == ADDR_ARRAY_CTRL);
    assign wr_amod = req.wr & (req.addr == ADDR_ARRAY_MODE);
    assign wr_pwmc = req.wr & (req.addr == ADDR_PWM_CTRL);

    pin_edge_detect #(
        .W       (NUM_CH)
    ) u_pins (
        .clk_i   (REF_CLK_I),
        .rst_i   (SYS_RST_I),
        .pin_i   (CH_PIN_I),
        .level_o (pin_lvl),
        .rise_o  (pin_rise),
        .fall_o  (pin_fall)
    );

    array_counter u_cnt (
        .clk_i      (REF_CLK_I),
        .rst_i      (SYS_RST_I),
        .step_i     (step),
        .wr_lo_i    (req.wr & (req.addr == ADDR_CNT_LO)),
        .wr_hi_i    (req.wr & (req.addr == ADDR_CNT_HI)),
        .wdata_i    (req.wdata),
        .cycle_length_sel_i    (cycle_length_sel_q),
        .cnt_o      (cnt),
        .wrap_o     (cnt_wrap),
        .mid_wrap_o (mid_wrap)
    );

    // shared flags and settings; a hardware set beats a software clear
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            run_q       <= 1'b0;
            wrap_flag_q <= 1'b0;
            mid_flag_q  <= 1'b0;
            wrap_ien_q  <= 1'b0;
            mid_ien_q   <= 1'b0;
            arsel_q     <= 1'b0;
            cycle_length_sel_q     <= CYCLE_LENGTH_SEL_RST;
        end else begin
            // flags persist until software writes them away
            wrap_flag_q <= cnt_wrap |
                (wr_ctrl ? req.wdata[ACTL_WRAP_BIT] : wrap_flag_q);
            mid_flag_q  <= mid_wrap |
                (wr_pwmc ? req.wdata[PWMC_FLAG_BIT] : mid_flag_q);
            if (wr_ctrl) begin
                run_q <= req.wdata[ACTL_RUN_BIT];
            end
            if (wr_amod) begin
                wrap_ien_q <= req.wdata[AMOD_IEN_BIT];
            end
            if (wr_pwmc) begin
                arsel_q   <= req.wdata[PWMC_ARSEL_BIT];
                mid_ien_q <= req.wdata[PWMC_IEN_BIT];
                cycle_length_sel_q   <= req.wdata[1:0];
            end
        end
    end

    // channel event flags, set wins over the clearing write
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            ch_flag_q <= '0;
        end else begin
            ch_flag_q <= ch_set |
                (wr_ctrl ? req.wdata[NUM_CH-1:0] : ch_flag_q);
        end
    end

    // the channels
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        mode_type m;
        logic     wr_mode;     // write to this mode register
        logic     wr_lo;       // write to low compare byte
        logic     wr_hi;       // write to high compare byte
        logic     is_cap;      // capture mode
        logic     is_pwm;      // any PWM mode
        logic     is_pulse_mode_en;     // 8..11-bit PWM
        logic     is_freq;     // frequency output
        logic     full_eq;     // 16-bit match
        logic     part_eq;     // low N-bit match
        logic     edge_hit;    // qualifying pin edge
        logic     cap_ev;      // capture now
        logic     tog_ev;      // toggle pin now
        logic     freq_hit;    // frequency low-byte match now
        logic     pwm_set;     // PWM rising edge now
        logic     pwm_clr;     // PWM falling edge now

        assign m       = mode_q[i];
        assign wr_mode = req.wr &
            (req.addr == chan_addr(ADDR_MODE_BASE, i, 1));
        assign wr_lo   = req.wr &
            (req.addr == chan_addr(ADDR_CMP_BASE, i, 2));
        assign wr_hi   = req.wr &
            (req.addr == chan_addr(ADDR_CMP_BASE + 8'h01, i, 2));

        // mode decode from the individual mode bits
        assign is_cap  = ~m.match_flag_en & ~m.toggle_en &
                         ~m.pulse_mode_en &
                         (m.rise_capture_sel | m.fall_capture_sel);
        assign is_pwm  = m.pulse_mode_en & ~m.toggle_en;
        assign is_pulse_mode_en = is_pwm & ~m.pwm16;
        assign is_freq = m.pulse_mode_en & m.toggle_en &
                         ~m.match_flag_en;

        assign full_eq = (cnt == cmp_q[i]);
        assign part_eq = ((cnt & mask) == (cmp_q[i] & mask));

        assign edge_hit = (m.rise_capture_sel & pin_rise[i]) |
                          (m.fall_capture_sel & pin_fall[i]);
        assign cap_ev   = step & is_cap & (pend_q[i] | edge_hit);

        // high-speed output toggle; dead with comparator off
        assign tog_ev   = step & m.comparator_en & m.toggle_en &
                          m.match_flag_en & ~m.pulse_mode_en &
                          full_eq;
        assign freq_hit = step & is_freq & m.comparator_en &
                          (cnt[7:0] == cmp_q[i][7:0]);
        assign pwm_set  = step & is_pwm & m.comparator_en &
                          (m.pwm16 ? full_eq : part_eq);
        assign pwm_clr  = m.pwm16 ? cnt_wrap : mid_wrap;

        // captures and software timer, toggle and PWM matches
        assign ch_set[i] = cap_ev |
            (step & m.comparator_en & m.match_flag_en & ~is_cap &
             (is_pulse_mode_en ? part_eq : full_eq));
        assign ch_ien[i] = m.channel_irq_en;

        // mode register and comparator enable
        always_ff @(posedge REF_CLK_I) begin
            if (SYS_RST_I) begin
                mode_q[i] <= mode_type'(MODE_RST);
            end else if (wr_mode) begin
                mode_q[i] <= mode_type'(req.wdata);
            end else if (wr_lo) begin
                mode_q[i].comparator_en <= 1'b0;
            end else if (wr_hi) begin
                mode_q[i].comparator_en <= 1'b1;
            end
        end

        // an edge seen between ticks is held so it is not lost
        always_ff @(posedge REF_CLK_I) begin
            if (SYS_RST_I) begin
                pend_q[i] <= 1'b0;
            end else if (step | ~is_cap) begin
                pend_q[i] <= 1'b0;
            end else if (edge_hit) begin
                pend_q[i] <= 1'b1;
            end
        end

        // compare/capture and reload registers; software write first
        always_ff @(posedge REF_CLK_I) begin
            if (SYS_RST_I) begin
                cmp_q[i] <= CMP_RST;
                rld_q[i] <= CMP_RST;
            end else if (wr_lo & arsel_q) begin
                rld_q[i][7:0] <= req.wdata;
            end else if (wr_hi & arsel_q) begin
                rld_q[i][15:8] <= req.wdata;
            end else if (wr_lo) begin
                cmp_q[i][7:0] <= req.wdata;
            end else if (wr_hi) begin
                cmp_q[i][15:8] <= req.wdata;
            end else if (cap_ev) begin
                cmp_q[i] <= cnt;
            end else if (freq_hit) begin
                // adding zero means the next match is 256 ticks on
                cmp_q[i][7:0] <= cmp_q[i][7:0] +
                                 cmp_q[i][15:8];
            end else if (is_pulse_mode_en & mid_wrap & m.comparator_en) begin
                if (cycle_length_sel_q == 2'h0) begin
                    cmp_q[i][7:0] <= cmp_q[i][15:8];
                end else begin
                    cmp_q[i] <= rld_q[i];
                end
            end
        end

        // pin driver; PWM clear wins over a coincident set
        always_ff @(posedge REF_CLK_I) begin
            if (SYS_RST_I) begin
                pin_q[i] <= 1'b0;
                oe_q[i]  <= 1'b0;
            end else begin
                oe_q[i] <= m.toggle_en | m.pulse_mode_en;
                if (is_pwm & ~m.comparator_en) begin
                    pin_q[i] <= 1'b0;
                end else if (is_pwm & pwm_clr) begin
                    pin_q[i] <= 1'b0;
                end else if (pwm_set) begin
                    pin_q[i] <= 1'b1;
                end else if (tog_ev | freq_hit) begin
                    pin_q[i] <= ~pin_q[i];
                end
                // comparator off in toggle modes: pin holds
            end
        end
    end

    // read image of array_control
    always_comb begin
        ctrl_rd = '0;
        ctrl_rd[ACTL_WRAP_BIT] = wrap_flag_q;
        ctrl_rd[ACTL_RUN_BIT]  = run_q;
        ctrl_rd[NUM_CH-1:0]    = ch_flag_q;
    end

    // register read mux; unmapped addresses read zero
    always_comb begin
        rd_data = '0;
        unique case (req.addr)
            ADDR_ARRAY_CTRL: rd_data = ctrl_rd;
            ADDR_ARRAY_MODE: rd_data[AMOD_IEN_BIT] = wrap_ien_q;
            ADDR_CNT_LO:     rd_data = cnt[7:0];
            ADDR_CNT_HI:     rd_data = cnt[15:8];
            ADDR_PWM_CTRL:   rd_data = {arsel_q, mid_ien_q, mid_flag_q,
                                        3'h0, cycle_length_sel_q};
            ADDR_PIN_STATE:  rd_data[NUM_CH-1:0] = pin_lvl;
            default:         rd_data = '0;
        endcase
        for (int k = 0; k < NUM_CH; k++) begin
            if (req.addr == chan_addr(ADDR_MODE_BASE, k, 1)) begin
                rd_data = mode_q[k];
            end
            if (req.addr == chan_addr(ADDR_CMP_BASE, k, 2)) begin
                rd_data = arsel_q ? rld_q[k][7:0] : cmp_q[k][7:0];
            end
            if (req.addr == chan_addr(ADDR_CMP_BASE + 8'h01, k, 2)) begin
                rd_data = arsel_q ? rld_q[k][15:8] : cmp_q[k][15:8];
            end
        end
    end

    // the processor adds its own global gating on top
    assign irq_d = (wrap_flag_q & wrap_ien_q) |
                   (mid_flag_q & mid_ien_q) |
                   (|(ch_flag_q & ch_ien));

    // registered outputs
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            SFR_RDATA_O <= '0;
            IRQ_O       <= 1'b0;
        end else begin
            IRQ_O <= irq_d;
            if (req.rd) begin
                SFR_RDATA_O <= rd_data;
            end
        end
    end

    assign CH_PIN_O    = pin_q;
    assign CH_PIN_OE_O = oe_q;
endmodule

// *** testbench/cc_asserts.sv ***
/* assertions on the array's top ports, bound to the top module.
   assumes one clock and a synchronous active-high reset */
`timescale 1ns/100ps
module cc_asserts
    import cc_pkg::*;
#(
    parameter int NUM_CH = 3
) (
    input wire logic              REF_CLK_I,
    input wire logic              SYS_RST_I,
    input wire logic              TICK_I,
    input wire logic              SFR_WR_I,
    input wire logic              SFR_RD_I,
    input wire logic [ADDR_W-1:0] SFR_ADDR_I,
    input wire logic [DATA_W-1:0] SFR_WDATA_I,
    input wire logic [NUM_CH-1:0] CH_PIN_I,
    input wire logic [DATA_W-1:0] SFR_RDATA_O,
    input wire logic [NUM_CH-1:0] CH_PIN_O,
    input wire logic [NUM_CH-1:0] CH_PIN_OE_O,
    input wire logic              IRQ_O
);
    logic [2:0] up_q; // edges since reset, saturating
    // keeps $past terms from looking back into a reset
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) up_q <= 3'h0;
        else if (up_q != 3'h7) up_q <= up_q + 3'h1;
    end
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    a_reset_outputs_idle:
        assert property ($fell(SYS_RST_I) |-> IRQ_O == 1'b0
            && CH_PIN_OE_O == '0) else $error("outputs busy after reset");
    a_unmapped_read_zero:
        assert property (SFR_RD_I && SFR_ADDR_I >= 8'h16
            |=> SFR_RDATA_O == 8'h00) else $error("unmapped read not zero");
    a_read_data_holds:
        assert property (!SFR_RD_I |=> $stable(SFR_RDATA_O))
        else $error("read data moved");
    a_pin_state_read:
        assert property (SFR_RD_I && SFR_ADDR_I == ADDR_PIN_STATE
            && up_q == 3'h7 && $stable(CH_PIN_I)
            && $past(CH_PIN_I, 2) == CH_PIN_I
            |=> SFR_RDATA_O[NUM_CH-1:0] == $past(CH_PIN_I))
        else $error("pin state read wrong");
    a_irq_rise_cause:
        assert property ($rose(IRQ_O) |-> $past(TICK_I, 2)
            || $past(SFR_WR_I, 2)) else $error("request rose uncaused");
    a_irq_drop_write:
        assert property ($fell(IRQ_O) && up_q != 3'h0
            |-> $past(SFR_WR_I, 2)) else $error("request dropped alone");
    a_pin_moves_step:
        assert property ($changed(CH_PIN_O) && up_q != 3'h0
            |-> $past(TICK_I) || $past(SFR_WR_I) || $past(SFR_WR_I, 2))
        else $error("pin moved off a step");
    a_oe_follows_mode:
        assert property ($changed(CH_PIN_OE_O) && up_q != 3'h0
            |-> $past(SFR_WR_I) || $past(SFR_WR_I, 2))
        else $error("pin enable moved without a write");
endmodule
bind counter_array_capture_compare cc_asserts #(.NUM_CH(NUM_CH))
    i_cc_asserts (.*);

// *** testbench/cc_pin_partner.sv ***
/* pin source beside the array: drives the pins the device leaves.
   assumes the bench sets want_i; the device wins where it drives */
`timescale 1ns/100ps
module cc_pin_partner #(
    parameter int NUM_CH = 3
) (
    input  wire logic              clk_i,
    input  wire logic [NUM_CH-1:0] want_i,   // level asked by the bench
    input  wire logic [NUM_CH-1:0] dev_i,    // device drive level
    input  wire logic [NUM_CH-1:0] dev_oe_i, // device drives the pin
    output logic      [NUM_CH-1:0] wire_o    // resolved pin level
);
    logic [NUM_CH-1:0] lvl_q = '0;   // level now on the source
    logic [1:0]        hold_q = 2'h0; // clocks that level has stood
    // a new level only after the old one stood three clocks
    always_ff @(posedge clk_i) begin
        if (hold_q < 2'h2) hold_q <= hold_q + 2'h1;
        else if (want_i != lvl_q) begin
            lvl_q  <= want_i;
            hold_q <= 2'h0;
        end
    end
    assign wire_o = (dev_oe_i & dev_i) | (~dev_oe_i & lvl_q);
endmodule

// *** testbench/counter_array_capture_compare_tb_top.sv ***
/* bench: register calls with expected values, ticks and pin edges.
   assumes cc_pkg, the pin partner and the bound checker */
`timescale 1ns/100ps
module counter_array_capture_compare_tb_top
    import cc_pkg::*;
;
    logic        clk = 1'b0;  // 20 MHz system clock
    logic        rst = 1'b1;  // synchronous reset
    logic        tick = 1'b0; // timebase step
    sfr_req_type req = '0;    // register port request
    logic [2:0]  want = 3'h0; // levels asked of the pin source
    logic [2:0]  pins, pin_o, pin_oe;
    logic [7:0]  rdata;
    logic        irq, hit;
    logic [1:0]  gate = 2'h3; // cpu global and array request enables
    logic [15:0] cnt, cap;    // expected counter and capture
    logic [7:0]  modes [4] = '{8'h10, 8'h20, 8'h20, 8'h30};
    int          miscompares = 0;
    int          n_checks = 0;
    initial begin
        forever #25 clk = ~clk;
    end
    counter_array_capture_compare #(
        .NUM_CH(3)
    ) i_counter_array_capture_compare (
        .REF_CLK_I(clk), .SYS_RST_I(rst), .TICK_I(tick),
        .SFR_WR_I(req.wr), .SFR_RD_I(req.rd), .SFR_ADDR_I(req.addr),
        .SFR_WDATA_I(req.wdata), .CH_PIN_I(pins), .SFR_RDATA_O(rdata),
        .CH_PIN_O(pin_o), .CH_PIN_OE_O(pin_oe), .IRQ_O(irq));
    cc_pin_partner #(.NUM_CH(3)) i_cc_pin_partner (.clk_i(clk),
        .want_i(want), .dev_i(pin_o), .dev_oe_i(pin_oe), .wire_o(pins));
    task automatic chk(input logic [15:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one register access; a read compares against d
    task automatic acc(input logic w, input logic [7:0] a, d);
        @(negedge clk);
        req = '{w, !w, a, d};
        @(negedge clk);
        req = '{1'b0, 1'b0, a, d};
        if (!w) chk({8'h00, rdata}, {8'h00, d});
    endtask
    task automatic step(input int n);
        repeat (n) begin
            @(negedge clk);
            tick = 1'b1;
            @(negedge clk);
            tick = 1'b0;
            cnt = cnt + 16'h1;
        end
    endtask
    task automatic setcnt(input logic [15:0] v);
        acc(1'b1, 8'h02, v[7:0]);
        acc(1'b1, 8'h03, v[15:8]);
        cnt = v;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // hang guard at 10000 cycles, over five times the roughly 1800 cycles the run takes
    initial begin
        #500000;
        miscompares++;
        stop_test();
    end
    initial begin
        cnt = 16'h0000;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        acc(1'b0, 8'h20, 8'h00);
        acc(1'b1, 8'h04, 8'h03);
        acc(1'b0, 8'h04, 8'h03);
        acc(1'b1, 8'h04, 8'h00);
        for (int c = 0; c < 3; c++) begin
            acc(1'b1, 8'h10 + 8'(2 * c), c == 2 ? 8'h03 : 8'h05);
            acc(1'b1, 8'h11 + 8'(2 * c), 8'h00);
        end
        acc(1'b1, 8'h08, 8'h49);
        acc(1'b1, 8'h10, 8'h05);
        acc(1'b0, 8'h08, 8'h09);
        acc(1'b1, 8'h11, 8'h00);
        acc(1'b0, 8'h08, 8'h49);
        acc(1'b1, 8'h09, 8'h48);
        acc(1'b1, 8'h0A, 8'h4C);
        acc(1'b1, 8'h00, 8'h40);
        step(4);
        acc(1'b0, 8'h00, 8'h44);
        chk(16'(pin_o[2]), 16'h1);
        chk(16'(irq), 16'h0);
        step(2);
        acc(1'b0, 8'h00, 8'h47);
        chk(16'(irq), 16'h1);
        step(10);
        acc(1'b0, 8'h00, 8'h47);
        acc(1'b0, 8'h02, cnt[7:0]);
        acc(1'b1, 8'h00, 8'h40);
        chk(16'(irq), 16'h1);
        acc(1'b0, 8'h00, 8'h40);
        chk(16'(irq), 16'h0);
        $display("compare test done");
        acc(1'b1, 8'h01, 8'h01);
        setcnt(16'hFFFE);
        step(2);
        acc(1'b0, 8'h00, 8'hC0);
        chk(16'(irq), 16'h1);
        chk(16'(irq & (&gate)), 16'h1);
        acc(1'b1, 8'h00, 8'h40);
        acc(1'b1, 8'h01, 8'h00);
        for (int s = 0; s < 4; s++) begin
            acc(1'b1, 8'h04, 8'(s));
            setcnt((16'h0100 << s) - 16'h1);
            step(1);
            acc(1'b0, 8'h04, 8'h20 | 8'(s));
        end
        acc(1'b1, 8'h04, 8'h00);
        $display("wrap test done");
        setcnt(16'h1234);
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, 8'h00, 8'h40);
            acc(1'b1, 8'h08, modes[i]);
            want[0] = ~want[0];
            repeat (8) @(negedge clk);
            step(1);
            hit = want[0] ? modes[i][5] : modes[i][4];
            cap = cnt - 16'h1;
            acc(1'b0, 8'h00, {7'h20, hit});
            if (hit) begin
                acc(1'b0, 8'h10, cap[7:0]);
                acc(1'b0, 8'h11, cap[15:8]);
            end
        end
        acc(1'b0, 8'h05, 8'h04);
        $display("capture test done");
        acc(1'b1, 8'h14, 8'h03);
        setcnt(16'h0003);
        step(1);
        chk(16'(pin_o[2]), 16'h1);
        acc(1'b1, 8'h09, 8'h02);
        acc(1'b0, 8'h09, 8'h02);
        chk({14'h0, pin_oe[1], pin_o[1]}, 16'h2);
        acc(1'b1, 8'h12, 8'h02);
        acc(1'b1, 8'h13, 8'h03);
        acc(1'b1, 8'h09, 8'h46);
        setcnt(16'h0000);
        step(3);
        chk(16'(pin_o[1]), 16'h1);
        step(3);
        chk(16'(pin_o[1]), 16'h0);
        acc(1'b0, 8'h12, 8'h08);
        acc(1'b1, 8'h13, 8'h00);
        step(258);
        chk(16'(pin_o[1]), 16'h1);
        step(1);
        chk(16'(pin_o[1]), 16'h0);
        acc(1'b1, 8'h04, 8'h80);
        acc(1'b1, 8'h10, 8'h11);
        acc(1'b0, 8'h10, 8'h11);
        acc(1'b1, 8'h04, 8'h00);
        acc(1'b0, 8'h10, cap[7:0]);
        acc(1'b1, 8'h10, 8'h05);
        acc(1'b1, 8'h11, 8'h05);
        acc(1'b1, 8'h08, 8'h4A);
        acc(1'b1, 8'h00, 8'h40);
        step(253);
        chk(16'(pin_o[0]), 16'h1);
        acc(1'b0, 8'h00, 8'h41);
        step(250);
        chk(16'(pin_o[0]), 16'h0);
        $display("output test done");
        stop_test();
    end
endmodule
